//--- hdl/isp_top.sv
// In-system flash programmer: register port, RAM reader, flash sequencer.
// Assumes a synchronous RAM read port (data one cycle after address) and
// a flash array that takes erase and program strobes of one cycle each.
//
// Function
// - Flash is 256 pages of 32 bytes.
// - Page base has low five bits zero.
// - Page source is 32 RAM bytes at pointer.
// - Page selected by target address bits 12:5.
// - Code 0x5A starts a page write.
// - Byte write uses target address bits 12:0.
// - Code 0x1E starts a single-byte write.
// - Buffer pointer is 8-bit RW, resets zero.
// - Target address bytes are RW, reset zero.
// - Each write erases then programs automatically.
// - A page write completes within 8 ms.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module isp_top #(
  parameter int WRITE_CYC = isp_pkg::ISP_WRITE_CYC,
  parameter int ERASE_CYC = isp_pkg::ISP_ERASE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  ram_addr,
  output logic             ram_rd,
  input  wire logic [7:0]  ram_rdata,
  output logic      [12:0] flash_addr,
  output logic      [7:0]  flash_wdata,
  output logic             flash_erase,
  output logic             flash_page,
  output logic             flash_prog,
  output logic             fetch_stall
);
  import isp_pkg::*;

  localparam int TW            = 24;
  localparam int PAGE_PROG_CYC = ISP_BYTE_CYC * ISP_PAGE_BYTES;

  // ==========================================================================
  // State
  typedef struct packed {
    isp_state_e  fsm;
    logic        page;
    logic [4:0]  idx;
    logic [7:0]  ptr;
    logic [15:0] base;
    logic        err;
    logic [7:0]  rdata;
    logic [12:0] faddr;
    logic [7:0]  fdata;
    logic        erase;
    logic        prog;
    logic        fetched;
  } isp_top_s;

  isp_top_s st_reg;
  isp_top_s st_next;

  logic [7:0]    ram_ptr;
  logic [15:0]   tgt_addr;
  logic          busy;
  logic          tmr_load;
  logic [TW-1:0] tmr_count;
  logic          tmr_expired;
  logic          cmd_wr;

  function automatic logic [7:0] isp_read_mux(input logic [7:0] a, input logic [7:0] p,
                                              input logic [15:0] t, input logic b,
                                              input logic e);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      ISP_OFS_RAM_PTR: r = p;
      ISP_OFS_ADDR_HI: r = t[15:8];
      ISP_OFS_ADDR_LO: r = t[7:0];
      ISP_OFS_STATUS: begin
        r[ISP_ST_BUSY] = b;
        r[ISP_ST_ERR]  = e;
      end
      default:         r = 8'h00;
    endcase
    return r;
  endfunction : isp_read_mux

  assign busy   = (st_reg.fsm != ISP_IDLE);
  assign cmd_wr = reg_wr && (reg_addr == ISP_OFS_CMD);

  // ==========================================================================
  // Registers
  // pointer and address
  isp_regs u_regs (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .reg_addr (reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr   (reg_wr),
    .lock     (busy),
    .ram_ptr  (ram_ptr),
    .tgt_addr (tgt_addr)
  );

  isp_timer #(.W(TW)) u_timer (
    .sys_clk(sys_clk),
    .rstn   (rstn),
    .load   (tmr_load),
    .count  (tmr_count),
    .expired(tmr_expired)
  );

  // ==========================================================================
  // Sequencer
  always_comb begin
    st_next       = st_reg;
    st_next.erase = 1'b0;
    st_next.prog  = 1'b0;
    tmr_load      = 1'b0;
    tmr_count     = '0;
    if (reg_rd) begin
      st_next.rdata = isp_read_mux(reg_addr, ram_ptr, tgt_addr, busy, st_reg.err);
    end
    unique case (st_reg.fsm)
      ISP_IDLE: begin
        if (cmd_wr) begin
          if (reg_wdata == ISP_CMD_PAGE || reg_wdata == ISP_CMD_BYTE) begin
            st_next.page  = (reg_wdata == ISP_CMD_PAGE);
            st_next.ptr   = ram_ptr;
            st_next.base  = (reg_wdata == ISP_CMD_PAGE) ?
                            {tgt_addr[15:ISP_PAGE_LSB], 5'h00} : tgt_addr;
            st_next.faddr = (reg_wdata == ISP_CMD_PAGE) ?
                            {tgt_addr[12:ISP_PAGE_LSB], 5'h00} : tgt_addr[12:0];
            st_next.idx   = 5'h00;
            st_next.erase = 1'b1;
            st_next.err   = 1'b0;
            st_next.fsm   = ISP_ERASE;
            tmr_load      = 1'b1;
            tmr_count     = TW'(ERASE_CYC - 1);
          end else begin
            st_next.err = 1'b1;
          end
        end
      end
      ISP_ERASE: begin
        if (tmr_expired) begin
          st_next.fsm     = ISP_FETCH;
          st_next.fetched = 1'b0;
        end
      end
      ISP_FETCH: begin
        st_next.fetched = 1'b1;
        if (st_reg.fetched) begin
          st_next.fdata = ram_rdata;
          st_next.faddr = st_reg.base[12:0] + {8'h00, st_reg.idx};
          st_next.prog  = 1'b1;
          st_next.fsm   = ISP_PROG;
        end
      end
      ISP_PROG: begin
        if (st_reg.page && st_reg.idx != ISP_LAST_IDX) begin
          st_next.idx     = st_reg.idx + 5'h01;
          st_next.fetched = 1'b0;
          st_next.fsm     = ISP_FETCH;
        end else begin
          st_next.fsm = ISP_WAIT;
          tmr_load    = 1'b1;
          // whole write, programming included, fits WRITE_CYC
          tmr_count   = st_reg.page ? TW'(WRITE_CYC - ERASE_CYC - 1 - PAGE_PROG_CYC) :
                                      TW'(WRITE_CYC - ERASE_CYC - 1 - ISP_BYTE_CYC);
        end
      end
      ISP_WAIT: begin
        if (tmr_expired) begin
          st_next.fsm = ISP_IDLE;
        end
      end
      default: st_next.fsm = ISP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg     <= '0;
      st_reg.fsm <= ISP_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata   = st_reg.rdata;
  assign ram_addr    = st_reg.ptr + {3'h0, st_reg.idx};
  assign ram_rd      = (st_reg.fsm == ISP_FETCH) && !st_reg.fetched;
  assign flash_addr  = st_reg.faddr;
  assign flash_wdata = st_reg.fdata;
  assign flash_erase = st_reg.erase;
  assign flash_page  = st_reg.page;
  assign flash_prog  = st_reg.prog;
  assign fetch_stall = busy;

  // ==========================================================================
  // Checks
  // page start
  page_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!busy && cmd_wr && reg_wdata == ISP_CMD_PAGE) |=> (flash_erase && flash_page && busy))
    else $error("page command did not start erase");

  byte_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!busy && cmd_wr && reg_wdata == ISP_CMD_BYTE) |=> (flash_erase && !flash_page))
    else $error("byte command did not start erase");

  bad_code_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!busy && cmd_wr && reg_wdata != ISP_CMD_PAGE && reg_wdata != ISP_CMD_BYTE)
    |=> (!busy && !flash_erase))
    else $error("reserved code started a write");

  page_align_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_erase && flash_page |-> flash_addr[4:0] == 5'h00)
    else $error("page erase not aligned");

  erase_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_erase |=> !flash_prog [*2])
    else $error("program too soon after erase");

  ram_seq_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ram_rd && st_reg.idx != 5'h00 |-> ram_addr == 8'($past(ram_addr, 3) + 8'h01))
    else $error("ram address out of sequence");

  stall_busy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog |-> fetch_stall)
    else $error("fetch not stalled during program");

  ptr_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (busy && $past(busy)) |-> $stable(ram_ptr))
    else $error("pointer changed during write");

  byte_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!busy && cmd_wr && reg_wdata == ISP_CMD_BYTE) |=> flash_addr == $past(tgt_addr[12:0]))
    else $error("byte target address wrong");

  ram_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    ram_rd && st_reg.idx == 5'h00 |-> ram_addr == ram_ptr)
    else $error("first ram address not the pointer");

  prog_order_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog |-> $past(ram_rd, 2))
    else $error("program without ram read");

  prog_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog |-> flash_wdata == $past(ram_rdata))
    else $error("program data not ram data");

  page_addr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog && flash_page |-> flash_addr[12:5] == tgt_addr[12:5])
    else $error("page program outside target page");

  byte_prog_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog && !flash_page |-> flash_addr == tgt_addr[12:0])
    else $error("byte program address wrong");

  page_count_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog && flash_page && flash_addr[4:0] == ISP_LAST_IDX |=> st_reg.fsm == ISP_WAIT)
    else $error("page did not end after last byte");

  byte_once_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_prog && !flash_page |=> st_reg.fsm == ISP_WAIT)
    else $error("byte write programmed more than once");

  erase_once_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_erase |=> !flash_erase [*8])
    else $error("erase repeated within a write");

  stall_erase_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    flash_erase |-> fetch_stall)
    else $error("erase while fetch runs");

  stall_rise_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(fetch_stall) |-> $past(cmd_wr && (reg_wdata == ISP_CMD_PAGE || reg_wdata == ISP_CMD_BYTE)))
    else $error("stall without a valid command");

  idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !fetch_stall |-> !flash_erase && !flash_prog && !ram_rd)
    else $error("flash or ram activity while idle");

  busy_cmd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    busy && cmd_wr |=> !flash_erase)
    else $error("command accepted while busy");

  addr_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (busy && $past(busy)) |-> $stable(tgt_addr))
    else $error("target address changed during write");

  ptr_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && reg_addr == ISP_OFS_RAM_PTR |=> reg_rdata == $past(ram_ptr))
    else $error("pointer read data wrong");

  addr_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && reg_addr == ISP_OFS_ADDR_HI |=> reg_rdata == $past(tgt_addr[15:8]))
    else $error("high address read data wrong");

  cmd_read_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_rd && reg_addr == ISP_OFS_CMD |=> reg_rdata == 8'h00)
    else $error("command register read not zero");

endmodule : isp_top

//--- hdl/isp_pkg.sv
// Constants for the in-system flash programmer.
// Assumes a 10 MHz system clock and an 8-bit register port.
package isp_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ISP_OFS_CMD      = 8'h94;
  localparam logic [7:0] ISP_OFS_ADDR_LO  = 8'h95;
  localparam logic [7:0] ISP_OFS_ADDR_HI  = 8'h96;
  localparam logic [7:0] ISP_OFS_RAM_PTR  = 8'h97;
  localparam logic [7:0] ISP_OFS_STATUS   = 8'h98;

  // ==========================================================================
  // Reset values and command codes
  localparam logic [7:0] ISP_RST_BYTE     = 8'h00;
  localparam logic [7:0] ISP_CMD_PAGE     = 8'h5a;
  localparam logic [7:0] ISP_CMD_BYTE     = 8'h1e;

  // ==========================================================================
  // Geometry
  localparam int         ISP_PAGE_BYTES   = 32;
  localparam int         ISP_PAGE_COUNT   = 256;
  localparam int         ISP_PAGE_LSB     = 5;
  localparam logic [4:0] ISP_LAST_IDX     = 5'h1f;

  // ==========================================================================
  // Timing
  localparam int         ISP_CLK_HZ       = 10_000_000;
  localparam int         ISP_WRITE_MAX_MS = 8;
  localparam int         ISP_ERASE_MS     = 3;
  localparam int         ISP_WRITE_CYC    = ISP_WRITE_MAX_MS * (ISP_CLK_HZ / 1000);
  localparam int         ISP_ERASE_CYC    = ISP_ERASE_MS * (ISP_CLK_HZ / 1000);
  // Cycles per byte: RAM read, data wait, program strobe
  localparam int         ISP_BYTE_CYC     = 3;

  // ==========================================================================
  // Status bit positions
  localparam int         ISP_ST_BUSY      = 0;
  localparam int         ISP_ST_ERR       = 1;

  typedef enum logic [2:0] {
    ISP_IDLE,
    ISP_ERASE,
    ISP_FETCH,
    ISP_PROG,
    ISP_WAIT
  } isp_state_e;

endpackage : isp_pkg

//--- hdl/isp_timer.sv
// Down counter that times the erase and the whole write.
// Assumes one clock domain; load is a one-cycle pulse.
`timescale 1ns/1ps
module isp_timer #(
  parameter int W = 24
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expired
);
  import isp_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
  } isp_tmr_s;

  isp_tmr_s st_reg;
  isp_tmr_s st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.cnt = count;
      st_next.run = 1'b1;
    end else if (st_reg.run) begin
      if (st_reg.cnt == '0) begin
        st_next.run = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.run && (st_reg.cnt == '0);

endmodule : isp_timer

//--- hdl/isp_regs.sv
// Register file: buffer pointer and target address pair.
// Assumes single-cycle strobes from the register port master.
`timescale 1ns/1ps
module isp_regs (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        lock,
  output logic      [7:0]  ram_ptr,
  output logic      [15:0] tgt_addr
);
  import isp_pkg::*;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] hi;
    logic [7:0] lo;
  } isp_regs_s;

  isp_regs_s st_reg;
  isp_regs_s st_next;

  always_comb begin
    st_next = st_reg;
    if (reg_wr && !lock) begin
      unique case (reg_addr)
        ISP_OFS_RAM_PTR: st_next.ptr = reg_wdata;
        ISP_OFS_ADDR_HI: st_next.hi  = reg_wdata;
        ISP_OFS_ADDR_LO: st_next.lo  = reg_wdata;
        default:         st_next     = st_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= {ISP_RST_BYTE, ISP_RST_BYTE, ISP_RST_BYTE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ram_ptr  = st_reg.ptr;
  assign tgt_addr = {st_reg.hi, st_reg.lo};

endmodule : isp_regs

//--- test/isp_mem_model.sv
// Partner model: internal RAM read port and the flash array.
// Assumes one-cycle RAM reads and one-cycle erase and program strobes.
`timescale 1ns/1ps
module isp_mem_model (
  input  wire logic [7:0]  salt,
  input  wire logic        sys_clk,
  input  wire logic [7:0]  ram_addr,
  input  wire logic        ram_rd,
  output logic      [7:0]  ram_rdata,
  input  wire logic [12:0] flash_addr,
  input  wire logic [7:0]  flash_wdata,
  input  wire logic        flash_erase,
  input  wire logic        flash_page,
  input  wire logic        flash_prog
);
  logic [7:0] flash [0:8191];
  initial begin
    for (int i = 0; i < 8192; i++)
      flash[i] = 8'hff;
    ram_rdata = 8'h00;
  end
  // ==========================================================================
  // RAM: stale data inverts each cycle, so a sample one cycle late is wrong
  always @(posedge sys_clk) begin
    if (ram_rd)
      ram_rdata <= (ram_addr * 8'h3b) ^ salt;
    else
      ram_rdata <= ~ram_rdata;
  end
  // ==========================================================================
  // erase then program
  // Programming only clears bits, so a missing erase shows
  always @(posedge sys_clk) begin
    if (flash_erase && flash_page)
      for (int i = 0; i < 32; i++)
        flash[{flash_addr[12:5], i[4:0]}] <= 8'hff;
    else if (flash_erase)
      flash[flash_addr] <= 8'hff;
    if (flash_prog)
      flash[flash_addr] <= flash_wdata & flash[flash_addr];
  end
endmodule : isp_mem_model

//--- test/testbench.sv
// Self-checking bench for the flash programmer with a reference image.
// Assumes short erase and write counts set through parameters.
`timescale 1ns/1ps
module testbench;
  import isp_pkg::*;
  localparam int WCYC = 120;
  localparam int ECYC = 10;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, ram_addr, ram_rdata, flash_wdata, salt, rd;
  logic        reg_wr, reg_rd, ram_rd, flash_erase, flash_page, flash_prog, fetch_stall;
  logic [12:0] flash_addr;
  logic [7:0]  exp_flash [0:8191];
  logic [7:0]  exp_v;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #50 sys_clk = ~sys_clk;
  isp_top #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) isp_top_inst (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_rdata(ram_rdata),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_erase(flash_erase),
    .flash_page(flash_page), .flash_prog(flash_prog), .fetch_stall(fetch_stall));
  isp_mem_model isp_mem_model_inst (.salt(salt), .sys_clk(sys_clk), .ram_addr(ram_addr),
    .ram_rd(ram_rd), .ram_rdata(ram_rdata), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_erase(flash_erase), .flash_page(flash_page),
    .flash_prog(flash_prog));
  // ==========================================================================
  // Tasks
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task finish_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rd_reg
  function automatic logic [7:0] ramv(input logic [7:0] a);
    return (a * 8'h3b) ^ salt;
  endfunction : ramv
  task run(input logic [7:0] cmd, input logic [7:0] p, input logic [15:0] t);
    int n;
    n = 0;
    // full setup and command, then two idle cycles
    wr(ISP_OFS_RAM_PTR, p);
    wr(ISP_OFS_ADDR_LO, t[7:0]);
    wr(ISP_OFS_ADDR_HI, t[15:8]);
    // the 20000-cycle Timeout watchdog runs beside this block
    wr(ISP_OFS_CMD, cmd);
    repeat (2) @(posedge sys_clk);
    #1 check("stall", {7'h0, fetch_stall}, 8'h01);
    wr(ISP_OFS_RAM_PTR, ~p);
    wr(ISP_OFS_CMD, cmd);
    rd_reg(ISP_OFS_STATUS);
    check("busy", {7'h0, rd[0]}, 8'h01);
    while (fetch_stall !== 1'b0 && n < 2000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("time", {7'h0, n <= WCYC}, 8'h01);
    rd_reg(ISP_OFS_RAM_PTR);
    check("ptr kept", rd, p);
    rd_reg(ISP_OFS_STATUS);
    check("status", rd, 8'h00);
    for (int i = 0; i < ISP_PAGE_BYTES; i++)
      if (cmd == ISP_CMD_PAGE)
        exp_flash[{t[12:5], 5'(i)}] = ramv(8'(p + i));
    if (cmd == ISP_CMD_BYTE)
      exp_flash[t[12:0]] = ramv(p);
    for (int i = 0; i < ISP_PAGE_BYTES; i++)
      check("flash", isp_mem_model_inst.flash[{t[12:5], 5'(i)}], exp_flash[{t[12:5], 5'(i)}]);
  endtask : run
  function automatic logic [15:0] tgt();
    return {3'($urandom), 8'(1 + $urandom % 254), 5'($urandom)};
  endfunction : tgt
  // ==========================================================================
  // Timeout
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    for (int i = 0; i < 8192; i++)
      exp_flash[i] = 8'hff;
    void'($urandom(32'h718babb6));
    salt = 8'($urandom);
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int a = 8'h94; a < 8'h98; a++) begin
      rd_reg(8'(a));
      check("reset", rd, ISP_RST_BYTE);
    end
    rd_reg(8'h10);
    check("unmapped", rd, 8'h00);
    for (int a = 8'h95; a < 8'h98; a++) begin
      exp_v = 8'($urandom);
      wr(8'(a), exp_v);
      rd_reg(8'(a));
      check("readback", rd, exp_v);
    end
    run(ISP_CMD_BYTE, 8'($urandom), tgt());
    run(ISP_CMD_PAGE, 8'($urandom), tgt());
    run(ISP_CMD_PAGE, 8'hf0, tgt());
    wr(ISP_OFS_CMD, 8'h33);
    repeat (2) @(posedge sys_clk);
    #1 check("no start", {7'h0, fetch_stall}, 8'h00);
    rd_reg(ISP_OFS_STATUS);
    check("err", {7'h0, rd[1]}, 8'h01);
    // Reset while idle clears registers and the error flag
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int a = 8'h95; a < 8'h99; a++) begin
      rd_reg(8'(a));
      check("rereset", rd, ISP_RST_BYTE);
    end
    run(ISP_CMD_BYTE, 8'($urandom), tgt());
    finish_test();
  end
endmodule : testbench
